// [hw/sac_top.sv]
// Overview of operation
// - twelve-bit result, seven pins plus internal reference
// - result register write starts conversion, idle clears
// - completion sets idle, loads result, raises done
// - high-nibble write start also requests sleep
// - disabled interrupt: no request, converter stays powered
// - result split low, mid, high nibbles, reset zero
// - channel codes 0-6 pins, 7 internal reference
// - clock code selects one of six rates, codes 0/5 and 3/7 shared
// - slow rate: fast/128 or slow oscillator
// - power bit off shuts converter, resets zero
// - status bit zero busy, one idle, resets one
// - route low bits hand pins 0-3 over
// - route high bits hand pins 4-6 over
`timescale 1ns/1ps
`default_nettype none

module sac_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        cpu_low_speed,
  input  wire logic        slow_oscillator,
  input  wire logic        comparator_above,
  output var  logic [11:0] sar_trial_code,
  output var  logic [2:0]  channel_code_field,
  output var  logic        converter_power_on,
  output var  logic [6:0]  external_analog_inputs_route,
  output var  logic        sleep_request,
  output var  logic        irq
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  // control and state
  sac_pkg::sac_ctrl_t  ctrl_r;
  sac_pkg::sac_state_t state_r;

  // channel and pin routing
  logic [3:0]  chan_sel_r;
  logic [3:0]  route_low_r;
  logic [2:0]  route_high_r;

  // approximation registers
  logic [11:0] result_r;
  logic [11:0] trial_r;
  logic [3:0]  bit_idx_r;

  // flags
  logic        idle_status_flag_r;
  logic        conversion_done_flag_r;
  logic        done_enable_r;
  logic        sleep_r;
  logic        irq_r;

  // conversion clock divider
  logic [9:0]  div_cnt_r;

  // synchroniser stages
  logic [1:0]  slow_sync_r;
  logic        slow_prev_r;
  logic [1:0]  cmp_sync_r;

  // registered bus answer
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  // decode signals
  logic [9:0]  idx;
  logic        aligned;
  logic        mapped;
  logic        wr_fire;

  // conversion start
  logic        start_req;
  logic        start_high;

  // conversion timing
  logic        conv_tick;
  logic        finish;
  logic        use_slow_osc;
  logic [9:0]  div_sel;

  // approximation datapath
  logic [11:0] decided;
  logic [11:0] bit_mask;
  logic [11:0] next_mask;

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  // only bits 1:0 both zero count as an aligned word access
  assign idx     = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign wr_fire = psel && penable && pready_r && pwrite && !pslverr_r;

  // decode of implemented word indices
  always_comb begin
    case (idx)
      sac_pkg::IDX_RESULT_LOW,
      sac_pkg::IDX_RESULT_MID,
      sac_pkg::IDX_RESULT_HIGH,
      sac_pkg::IDX_CHANNEL_SEL,
      sac_pkg::IDX_CONV_CONTROL,
      sac_pkg::IDX_CONV_STATUS,
      sac_pkg::IDX_ROUTE_LOW,
      sac_pkg::IDX_ROUTE_HIGH,
      sac_pkg::IDX_INT_FLAG_ONE,
      sac_pkg::IDX_INT_ENABLE: mapped = aligned;
      default:                 mapped = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // conversion start
  // ---------------------------------------------------------------------------

  // a write to any result nibble starts a conversion while powered
  assign start_req  = wr_fire && ctrl_r.converter_power_on &&
                      (idx == sac_pkg::IDX_RESULT_LOW ||
                       idx == sac_pkg::IDX_RESULT_MID ||
                       idx == sac_pkg::IDX_RESULT_HIGH);
  assign start_high = start_req && (idx == sac_pkg::IDX_RESULT_HIGH);

  // ---------------------------------------------------------------------------
  // apb slave: answer prepared in setup, pready high in access phase
  // ---------------------------------------------------------------------------
  // unmapped or misaligned reads answer zero along with the error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= psel && !penable;
      pslverr_r <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite && mapped) begin
        case (idx)
          sac_pkg::IDX_RESULT_LOW:   prdata_r <= {28'h0, result_r[3:0]};
          sac_pkg::IDX_RESULT_MID:   prdata_r <= {28'h0, result_r[7:4]};
          sac_pkg::IDX_RESULT_HIGH:  prdata_r <= {28'h0, result_r[11:8]};
          sac_pkg::IDX_CHANNEL_SEL:  prdata_r <= {28'h0, chan_sel_r};
          sac_pkg::IDX_CONV_CONTROL: prdata_r <= {28'h0, ctrl_r};
          sac_pkg::IDX_CONV_STATUS:  prdata_r <= {31'h0, idle_status_flag_r};
          sac_pkg::IDX_ROUTE_LOW:    prdata_r <= {28'h0, route_low_r};
          sac_pkg::IDX_ROUTE_HIGH:   prdata_r <= {29'h0, route_high_r};
          sac_pkg::IDX_INT_FLAG_ONE: prdata_r <= {31'h0, conversion_done_flag_r};
          sac_pkg::IDX_INT_ENABLE:   prdata_r <= {31'h0, done_enable_r};
          default:                   prdata_r <= 32'h0000_0000;
        endcase
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------------------
  // writes land only at the access edge of an accepted transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r        <= sac_pkg::RST_NIBBLE;
      chan_sel_r    <= sac_pkg::RST_NIBBLE;
      route_low_r   <= sac_pkg::RST_NIBBLE;
      route_high_r  <= sac_pkg::RST_NIBBLE[2:0];
      done_enable_r <= 1'b0;
    end else if (wr_fire) begin
      case (idx)
        sac_pkg::IDX_CONV_CONTROL: ctrl_r        <= pwdata[3:0];
        sac_pkg::IDX_CHANNEL_SEL:  chan_sel_r    <= pwdata[3:0];
        sac_pkg::IDX_ROUTE_LOW:    route_low_r   <= pwdata[3:0];
        sac_pkg::IDX_ROUTE_HIGH:   route_high_r  <= pwdata[2:0];
        sac_pkg::IDX_INT_ENABLE:   done_enable_r <= pwdata[sac_pkg::POS_DONE_FLAG];
        default:                   ctrl_r        <= ctrl_r;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------------------
  // only the second stage feeds logic, the first may be metastable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_sync_r <= 2'h0;
      slow_prev_r <= 1'b0;
      cmp_sync_r  <= 2'h0;
    end else begin
      slow_sync_r <= {slow_sync_r[0], slow_oscillator};
      slow_prev_r <= slow_sync_r[1];
      cmp_sync_r  <= {cmp_sync_r[0], comparator_above};
    end
  end

  // ---------------------------------------------------------------------------
  // conversion clock selection
  // ---------------------------------------------------------------------------
  always_comb begin
    use_slow_osc = 1'b0;
    case (ctrl_r.conversion_clock_code)
      3'h0:    div_sel = sac_pkg::DIV_1MHZ;
      3'h1:    div_sel = sac_pkg::DIV_250K;
      3'h2:    div_sel = sac_pkg::DIV_125K;
      3'h4:    div_sel = sac_pkg::DIV_2MHZ;
      3'h5:    div_sel = sac_pkg::DIV_1MHZ;
      3'h6:    div_sel = sac_pkg::DIV_500K;
      default: begin
        div_sel      = sac_pkg::DIV_SLOW;
        use_slow_osc = cpu_low_speed;
      end
    endcase
  end

  // tick is either the divider wrap or a slow oscillator rising edge
  assign conv_tick = (state_r == sac_pkg::SAC_CONVERT) &&
                     (use_slow_osc ? (slow_sync_r[1] && !slow_prev_r)
                                   : (div_cnt_r == div_sel - 10'h001));

  // ---------------------------------------------------------------------------
  // conversion divider
  // ---------------------------------------------------------------------------

  // divider restarts with every conversion so the first step is full length
  // a count left above a new, smaller divisor is cleared rather than wrapped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= 10'h000;
    end else if (state_r != sac_pkg::SAC_CONVERT || conv_tick || div_cnt_r >= div_sel) begin
      div_cnt_r <= 10'h000;
    end else begin
      div_cnt_r <= div_cnt_r + 10'h001;
    end
  end

  // ---------------------------------------------------------------------------
  // successive approximation
  // ---------------------------------------------------------------------------
  assign bit_mask  = 12'h001 << bit_idx_r;
  assign next_mask = bit_mask >> 1;
  assign decided   = cmp_sync_r[1] ? trial_r : (trial_r & ~bit_mask);
  assign finish    = conv_tick && (bit_idx_r == 4'h0);

  // sequencer: one bit decided per conversion clock, msb first
  // power loss aborts at once and leaves the stored result alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= sac_pkg::SAC_IDLE;
      trial_r   <= sac_pkg::RST_RESULT;
      bit_idx_r <= 4'h0;
    end else begin
      case (state_r)
        sac_pkg::SAC_IDLE: begin
          if (start_req) begin
            state_r   <= sac_pkg::SAC_CONVERT;
            trial_r   <= sac_pkg::SAR_FIRST_TRIAL;
            bit_idx_r <= sac_pkg::SAR_MSB_IDX;
          end
        end
        sac_pkg::SAC_CONVERT: begin
          if (!ctrl_r.converter_power_on) begin
            state_r <= sac_pkg::SAC_IDLE;
          end else if (finish) begin
            state_r <= sac_pkg::SAC_IDLE;
            trial_r <= decided;
          end else if (conv_tick) begin
            trial_r   <= decided | next_mask;
            bit_idx_r <= bit_idx_r - 4'h1;
          end
        end
        default: state_r <= sac_pkg::SAC_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // result and status
  // ---------------------------------------------------------------------------

  // result held through the conversion, all nibbles loaded together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_r <= sac_pkg::RST_RESULT;
    end else if (finish && ctrl_r.converter_power_on) begin
      result_r <= decided;
    end
  end

  // idle flag low while converting
  // an abort by power loss also returns the flag to idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_status_flag_r <= sac_pkg::RST_STATUS[sac_pkg::POS_IDLE_FLAG];
    end else if (start_req && state_r == sac_pkg::SAC_IDLE) begin
      idle_status_flag_r <= 1'b0;
    end else if (state_r == sac_pkg::SAC_CONVERT &&
                 (finish || !ctrl_r.converter_power_on)) begin
      idle_status_flag_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // sleep control
  // ---------------------------------------------------------------------------

  // sleep held from a high-nibble start until the conversion ends
  // a start during a conversion is ignored and cannot re-arm sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_r <= 1'b0;
    end else if (start_high && state_r == sac_pkg::SAC_IDLE) begin
      sleep_r <= 1'b1;
    end else if (state_r == sac_pkg::SAC_IDLE) begin
      sleep_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // interrupt: sticky done flag, write one to clear, set wins
  // ---------------------------------------------------------------------------
  // a completion in the same cycle as a clear keeps the flag set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_done_flag_r <= 1'b0;
    end else if (finish && ctrl_r.converter_power_on) begin
      conversion_done_flag_r <= 1'b1;
    end else if (wr_fire && idx == sac_pkg::IDX_INT_FLAG_ONE &&
                 pwdata[sac_pkg::POS_DONE_FLAG]) begin
      conversion_done_flag_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // interrupt level
  // ---------------------------------------------------------------------------

  // interrupt level, masked by the enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= conversion_done_flag_r && done_enable_r;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  // every output is a flip-flop or a plain bundle of flip-flops
  assign prdata                       = prdata_r;
  assign pready                       = pready_r;
  assign pslverr                      = pslverr_r;
  assign sar_trial_code               = trial_r;
  assign channel_code_field           = chan_sel_r[2:0];
  assign converter_power_on           = ctrl_r.converter_power_on;
  assign external_analog_inputs_route = {route_high_r, route_low_r};
  assign sleep_request                = sleep_r;
  assign irq                          = irq_r;

endmodule // sac_top

`default_nettype wire

// [hw/sac_pkg.sv]
package sac_pkg;

  // ---------------------------------------------------------------------------
  // timing: conversion clock rates derived from the 100 MHz bus clock
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_FREQ_KHZ = 100000;
  localparam int unsigned F_2MHZ_KHZ   = 2000;
  localparam int unsigned F_1MHZ_KHZ   = 1000;
  localparam int unsigned F_500K_KHZ   = 500;
  localparam int unsigned F_250K_KHZ   = 250;
  localparam int unsigned F_125K_KHZ   = 125;
  localparam logic [9:0]  DIV_2MHZ     = 10'(CLK_FREQ_KHZ / F_2MHZ_KHZ);
  localparam logic [9:0]  DIV_1MHZ     = 10'(CLK_FREQ_KHZ / F_1MHZ_KHZ);
  localparam logic [9:0]  DIV_500K     = 10'(CLK_FREQ_KHZ / F_500K_KHZ);
  localparam logic [9:0]  DIV_250K     = 10'(CLK_FREQ_KHZ / F_250K_KHZ);
  localparam logic [9:0]  DIV_125K     = 10'(CLK_FREQ_KHZ / F_125K_KHZ);
  localparam logic [9:0]  DIV_SLOW     = 10'h080;   // fast oscillator / 128

  // ---------------------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ---------------------------------------------------------------------------
  localparam logic [9:0] IDX_RESULT_LOW   = 10'h290;
  localparam logic [9:0] IDX_RESULT_MID   = 10'h291;
  localparam logic [9:0] IDX_RESULT_HIGH  = 10'h292;
  localparam logic [9:0] IDX_CHANNEL_SEL  = 10'h293;
  localparam logic [9:0] IDX_CONV_CONTROL = 10'h294;
  localparam logic [9:0] IDX_CONV_STATUS  = 10'h296;
  localparam logic [9:0] IDX_ROUTE_LOW    = 10'h297;
  localparam logic [9:0] IDX_ROUTE_HIGH   = 10'h298;
  localparam logic [9:0] IDX_INT_FLAG_ONE = 10'h299;
  localparam logic [9:0] IDX_INT_ENABLE   = 10'h29A;

  // ---------------------------------------------------------------------------
  // reset values and field positions
  // ---------------------------------------------------------------------------
  localparam logic [3:0]  RST_NIBBLE      = 4'h0;
  localparam logic [3:0]  RST_STATUS      = 4'h1;
  localparam logic [11:0] RST_RESULT      = 12'h000;
  localparam logic [11:0] SAR_FIRST_TRIAL = 12'h800;
  localparam logic [3:0]  SAR_MSB_IDX     = 4'hB;
  localparam int unsigned POS_IDLE_FLAG   = 0;
  localparam int unsigned POS_DONE_FLAG   = 0;
  localparam int unsigned POS_POWER_ON    = 3;

  typedef struct packed {
    logic       converter_power_on;
    logic [2:0] conversion_clock_code;
  } sac_ctrl_t;

  typedef enum {SAC_IDLE, SAC_CONVERT} sac_state_t;

endpackage

// [dv/sac_top_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module sac_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        converter_power_on,
  input wire logic [2:0]  channel_code_field,
  input wire logic [6:0]  external_analog_inputs_route,
  input wire logic        sleep_request,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ---------------------------------------------
  // address decode and bus sequences
  // ---------------------------------------------
  logic [9:0] idx;
  logic       mapped;
  logic       hi_start;
  assign idx = paddr[11:2];
  assign mapped = paddr[1:0] == 2'h0 && idx >= sac_pkg::IDX_RESULT_LOW
                  && idx <= sac_pkg::IDX_INT_ENABLE && idx != 10'h295;
  assign hi_start = psel && penable && pwrite && idx == sac_pkg::IDX_RESULT_HIGH;
  sequence setup_cyc;
    psel && !penable;
  endsequence
  sequence wr_done(logic [9:0] i);
    psel && penable && pready && pwrite && !pslverr && idx == i;
  endsequence
  AST_ACCESS_NEXT: assert property (setup_cyc |=> pready) else $error("no access answer");
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready held");
  AST_UNMAPPED_ERR: assert property (setup_cyc and !mapped |=> pready && pslverr)
    else $error("unmapped not refused");
  AST_CHANNEL: assert property (
    wr_done(sac_pkg::IDX_CHANNEL_SEL) |=> channel_code_field == $past(pwdata[2:0]))
    else $error("channel not updated");
  AST_POWER: assert property (
    wr_done(sac_pkg::IDX_CONV_CONTROL) |=> converter_power_on == $past(pwdata[3]))
    else $error("power bit not updated");
  AST_ROUTE_LOW: assert property (
    wr_done(sac_pkg::IDX_ROUTE_LOW) |=> external_analog_inputs_route[3:0] == $past(pwdata[3:0]))
    else $error("low route wrong");
  AST_ROUTE_HIGH: assert property (
    wr_done(sac_pkg::IDX_ROUTE_HIGH) |=> external_analog_inputs_route[6:4] == $past(pwdata[2:0]))
    else $error("high route wrong");
  AST_SLEEP_CAUSE: assert property ($rose(sleep_request) |-> $past(hi_start))
    else $error("sleep without high start");
  AST_SLEEP_ABORT: assert property ($fell(converter_power_on) |-> ##[0:2] !sleep_request)
    else $error("sleep kept after power off");
  AST_STATUS_BITS: assert property (
    psel && penable && pready && !pwrite && idx == sac_pkg::IDX_CONV_STATUS |-> prdata[31:1] == 31'h0)
    else $error("status upper bits set");
  AST_IRQ_POWERED: assert property ($rose(irq) |-> converter_power_on)
    else $error("irq without power");
endmodule // sac_chk
bind sac_top sac_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .converter_power_on, .channel_code_field,
  .external_analog_inputs_route, .sleep_request, .irq);
`default_nettype wire

// [dv/sac_analog_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sac_analog_model #(
  parameter logic [11:0] REF_CODE  = 12'h9B0,
  parameter int          SLOW_HALF = 40
) (
  input wire logic        pclk,
  input wire logic [11:0] sar_trial_code,
  input wire logic [2:0]  channel_code_field,
  input wire logic        converter_power_on,
  input wire logic [6:0]  external_analog_inputs_route,
  output var logic        comparator_above,
  output var logic        slow_oscillator
);
  logic [11:0] analog_level [7];
  logic        noise = 1'b0;
  logic        open_in;
  int          slow_cnt = 0;
  initial comparator_above = 1'b0;
  initial slow_oscillator = 1'b0;
  // seven routed pins plus the internal reference on code 7
  assign open_in = channel_code_field != 3'h7
                   && !external_analog_inputs_route[channel_code_field];
  // comparator; unpowered or unrouted input gives a toggling level
  always @(posedge pclk) begin
    noise <= ~noise;
    if (!converter_power_on || open_in) begin
      comparator_above <= noise;
    end else if (channel_code_field == 3'h7) begin
      comparator_above <= REF_CODE >= sar_trial_code;
    end else begin
      comparator_above <= analog_level[channel_code_field] >= sar_trial_code;
    end
  end
  // slow oscillator runs free, sleep included
  always @(posedge pclk) begin
    slow_cnt <= (slow_cnt == SLOW_HALF - 1) ? 0 : slow_cnt + 1;
    if (slow_cnt == SLOW_HALF - 1) begin
      slow_oscillator <= ~slow_oscillator;
    end
  end
endmodule // sac_analog_model
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int SLOW_HALF = 40;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        cpu_low_speed = 1'b0;
  logic [1:0]  skew = 2'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, comparator_above, slow_oscillator;
  logic        converter_power_on, sleep_request, irq;
  logic [11:0] sar_trial_code;
  logic [11:0] last_res = 12'h000;
  logic [2:0]  channel_code_field;
  logic [6:0]  external_analog_inputs_route;
  logic [32:0] exp_q [$];
  logic [15:0] lfsr = 16'h5C30;
  int          mismatches = 0;
  int          num_checks = 0;
  int          divs [8];
  always #5 pclk = ~pclk;
  sac_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cpu_low_speed, .slow_oscillator, .comparator_above, .sar_trial_code,
    .channel_code_field, .converter_power_on, .external_analog_inputs_route,
    .sleep_request, .irq);
  sac_analog_model #(.SLOW_HALF(SLOW_HALF)) u_model (.pclk, .sar_trial_code,
    .channel_code_field, .converter_power_on, .external_analog_inputs_route,
    .comparator_above, .slow_oscillator);
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    num_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, seen, want);
    end
  endtask
  task automatic complete_run();
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // one transfer; expected {error, read nibble} is queued for the monitor
  task automatic apb(input logic wr, input logic [9:0] i, input logic [3:0] d,
                     input logic er, input logic [3:0] rd);
    int n;
    n = 0;
    exp_q.push_back({er, 28'h0, rd});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {i, skew};
    pwdata <= {28'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // monitor: each completed transfer against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      check({pslverr, prdata & {32{~pwrite}}}, exp_q.pop_front());
    end
  end
  // conversion on channel c, clock code k, started through result register r
  task automatic convert(input logic [2:0] c, input logic [2:0] k, input logic [1:0] r);
    logic [11:0] v;
    int          step;
    int          cyc;
    time         t0;
    int          slack;
    v = (c == 3'h7) ? 12'h9B0 : 12'(rnd());
    if (c != 3'h7) u_model.analog_level[c] = v;
    apb(1, sac_pkg::IDX_CHANNEL_SEL, {1'b0, c}, 0, 0);
    apb(1, sac_pkg::IDX_CONV_CONTROL, {1'b1, k}, 0, 0);
    // speed level has settled here; the free slow oscillator adds up to one step of phase
    step = (cpu_low_speed && k[1:0] == 2'h3) ? 2 * SLOW_HALF : divs[k];
    slack = (cpu_low_speed && k[1:0] == 2'h3) ? step : 0;
    apb(1, sac_pkg::IDX_RESULT_LOW + 10'(r), 4'h0, 0, 0);
    t0 = $time;
    apb(0, sac_pkg::IDX_CONV_STATUS, 0, 0, 4'h0);
    apb(0, sac_pkg::IDX_RESULT_MID, 0, 0, last_res[7:4]);
    check(sleep_request, r == 2'h2);
    while (irq !== 1'b1 && ($time - t0) < 200000) @(posedge pclk);
    cyc = int'(($time - t0) / 10);
    check(cyc >= 12 * step - 10 - slack && cyc <= 12 * step + 10 + step / 2, 1);
    check(sleep_request, 0);
    for (int i = 0; i < 3; i++) begin
      apb(0, sac_pkg::IDX_RESULT_LOW + 10'(i), 0, 0, v[4*i +: 4]);
    end
    apb(0, sac_pkg::IDX_CONV_STATUS, 0, 0, 4'h1);
    apb(1, sac_pkg::IDX_INT_FLAG_ONE, 4'h1, 0, 0);
    repeat (2) @(posedge pclk);
    check(irq, 0);
    last_res = v;
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    logic [3:0] d;
    divs = '{sac_pkg::DIV_1MHZ, sac_pkg::DIV_250K, sac_pkg::DIV_125K, sac_pkg::DIV_SLOW,
             sac_pkg::DIV_2MHZ, sac_pkg::DIV_1MHZ, sac_pkg::DIV_500K, sac_pkg::DIV_SLOW};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      apb(0, sac_pkg::IDX_RESULT_LOW + 10'(i), 0, i == 5, (i == 6) ? 4'h1 : 4'h0);
    end
    skew <= 2'h1;
    apb(0, sac_pkg::IDX_CONV_STATUS, 0, 1, 0);
    skew <= 2'h0;
    apb(1, sac_pkg::IDX_RESULT_HIGH, 4'h0, 0, 0);
    apb(0, sac_pkg::IDX_CONV_STATUS, 0, 0, 4'h1);
    check(sleep_request, 0);
    for (int i = 0; i < 4; i++) begin
      d = 4'(rnd());
      apb(1, sac_pkg::IDX_ROUTE_LOW, d, 0, 0);
      apb(1, sac_pkg::IDX_ROUTE_HIGH, d, 0, 0);
      apb(0, sac_pkg::IDX_ROUTE_HIGH, 0, 0, {1'b0, d[2:0]});
      check(external_analog_inputs_route, {d[2:0], d});
    end
    apb(1, sac_pkg::IDX_ROUTE_LOW, 4'hF, 0, 0);
    apb(1, sac_pkg::IDX_ROUTE_HIGH, 4'h7, 0, 0);
    apb(1, sac_pkg::IDX_INT_ENABLE, 4'h1, 0, 0);
    for (int k = 0; k < 8; k++) begin
      if (k == 7) cpu_low_speed <= 1'b1;
      convert(3'(k), 3'(k), 2'(k % 3));
    end
    apb(1, sac_pkg::IDX_INT_ENABLE, 4'h0, 0, 0);
    apb(1, sac_pkg::IDX_RESULT_MID, 4'h0, 0, 0);
    repeat (12 * 128 + 40) @(posedge pclk);
    check({irq, converter_power_on}, 2'h1);
    apb(0, sac_pkg::IDX_INT_FLAG_ONE, 0, 0, 4'h1);
    apb(1, sac_pkg::IDX_INT_ENABLE, 4'h1, 0, 0);
    repeat (2) @(posedge pclk);
    check(irq, 1);
    apb(1, sac_pkg::IDX_INT_FLAG_ONE, 4'h1, 0, 0);
    apb(1, sac_pkg::IDX_RESULT_HIGH, 4'h0, 0, 0);
    apb(1, sac_pkg::IDX_CONV_CONTROL, 4'h3, 0, 0);
    apb(0, sac_pkg::IDX_CONV_STATUS, 0, 0, 4'h1);
    check({sleep_request, irq}, 0);
    complete_run();
  end
  // watchdog
  initial begin
    #1000000;
    mismatches++;
    complete_run();
  end
endmodule // tb
`default_nettype wire
